//--- src/edie_pkg.sv
/*
  Package for the DMA interrupt enable block: APB offsets, enable bit positions,
  status event positions, summary group masks and reset values.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
`default_nettype none
package edie_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_STATUS  = 12'h014;
  localparam logic [11:0] OFF_ENABLE  = 12'h01C;
  localparam logic [11:0] OFF_EVENT   = 12'h020;
  // ----------------------------------------------------------------
  // Enable and status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_DONE      = 0;
  localparam int BIT_RX_BUF_UNAV  = 7;
  localparam int BIT_RX_STOPPED   = 8;
  localparam int BIT_RX_WDOG      = 9;
  localparam int BIT_EARLY_TX     = 10;
  localparam int BIT_FATAL_BUS    = 13;
  localparam int BIT_EARLY_RX     = 14;
  localparam int BIT_ABN_SUM      = 15;
  localparam int BIT_NRM_SUM      = 16;
  localparam int EVENT_W          = 15;
  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] ABN_GROUP   = 15'h27BA;
  localparam logic [14:0] NRM_GROUP   = 15'h4045;
  localparam logic [31:0] ENABLE_WMASK = 32'h0001E7FF;
  localparam logic [31:0] ENABLE_RST  = 32'h00000000;
  localparam logic [14:0] STATUS_RST  = 15'h0000;
endpackage
`default_nettype wire

//--- src/edie_gate.sv
/*
  Combinational gating of status events by individual and summary enables.
  Assumes enables and status come from registers on the same clock.
*/
`default_nettype none
module edie_gate (
  input  wire logic [31:0] enableReg,
  input  wire logic [14:0] statusReg,
  output logic      [14:0] gated
);
  // ----------------------------------------------------------------
  // Gating
  // ----------------------------------------------------------------
  logic [14:0] groupEn;
  always_comb begin
    groupEn = ({15{enableReg[edie_pkg::BIT_ABN_SUM]}} & edie_pkg::ABN_GROUP)
            | ({15{enableReg[edie_pkg::BIT_NRM_SUM]}} & edie_pkg::NRM_GROUP);
    gated   = statusReg & enableReg[14:0] & groupEn & ~15'h1800;
  end
endmodule
`default_nettype wire

//--- src/edie_apb.sv
/*
  APB slave decode helper: flags a completed write or read in the access phase.
  Assumes zero-wait-state answers; pready is always high.
*/
`default_nettype none
module edie_apb (
  input  wire logic psel,
  input  wire logic penable,
  input  wire logic pwrite,
  output logic      wrStb,
  output logic      rdStb
);
  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  always_comb begin
    wrStb = psel & penable & pwrite;
    rdStb = psel & penable & ~pwrite;
  end
endmodule
`default_nettype wire

//--- src/edie_top.sv
/*
  DMA interrupt enable block with sticky status, APB access and one level
  interrupt output.
  Assumes a 20 MHz clock, asynchronous active-high reset, and events arriving
  as single-cycle pulses from logic on the same clock.
*/
// The APB register port and the register offsets are this design's own decisions.
`default_nettype none
module edie_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [14:0] dmaEvent,
  output logic             dmaIrq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] enable;
    logic [14:0] status;
    logic [31:0] rdata;
    logic        irq;
  } edie_state_s;

  edie_state_s st_r;
  edie_state_s st_nxt;
  logic        wrStb;
  logic        rdStb;
  logic [14:0] gated;
  logic        mapped;
  logic [31:0] wmask;

  edie_apb u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .wrStb   (wrStb),
    .rdStb   (rdStb)
  );

  edie_gate u_gate (
    .enableReg (st_r.enable),
    .statusReg (st_r.status),
    .gated     (gated)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    mapped = (paddr == edie_pkg::OFF_STATUS) || (paddr == edie_pkg::OFF_ENABLE)
          || (paddr == edie_pkg::OFF_EVENT);
    wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    if (wrStb && paddr == edie_pkg::OFF_ENABLE) begin
      st_nxt.enable = (st_r.enable & ~wmask)
                    | (pwdata & wmask & edie_pkg::ENABLE_WMASK);
    end
    // Write one to clear, then set wins over clear; no enable involved
    if (wrStb && paddr == edie_pkg::OFF_STATUS) begin
      st_nxt.status = st_r.status & ~(pwdata[14:0] & wmask[14:0]);
    end
    st_nxt.status = st_nxt.status | dmaEvent;
    if (rdStb) begin
      case (paddr)
        edie_pkg::OFF_STATUS: st_nxt.rdata = {17'h00000, st_r.status};
        edie_pkg::OFF_ENABLE: st_nxt.rdata = st_r.enable;
        edie_pkg::OFF_EVENT:  st_nxt.rdata = {17'h00000, gated};
        default:              st_nxt.rdata = 32'h00000000;
      endcase
    end
    st_nxt.irq = |gated;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.enable <= edie_pkg::ENABLE_RST;
      st_r.status <= edie_pkg::STATUS_RST;
      st_r.rdata  <= 32'h00000000;
      st_r.irq    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    pready  = 1'b1;
    pslverr = psel & penable & ~mapped;
    prdata  = rdStb ? st_nxt.rdata : st_r.rdata;
    dmaIrq  = st_r.irq;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rxbu_pending;
    st_r.status[edie_pkg::BIT_RX_BUF_UNAV] && st_r.enable[edie_pkg::BIT_RX_BUF_UNAV]
      && st_r.enable[edie_pkg::BIT_ABN_SUM];
  endsequence
  property p_rxbu;
    @(posedge clk) disable iff (sys_rst) s_rxbu_pending |=> dmaIrq;
  endproperty
  a_rxbu: assert property (p_rxbu) else $error("rx buffer unavailable irq missing");
  property p_rxstop;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_RX_STOPPED] |-> !gated[edie_pkg::BIT_RX_STOPPED];
  endproperty
  a_rxstop: assert property (p_rxstop) else $error("rx stopped irq not masked");
  property p_wdog;
    @(posedge clk) disable iff (sys_rst)
      gated[edie_pkg::BIT_RX_WDOG] |-> st_r.enable[edie_pkg::BIT_ABN_SUM];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog irq without summary");
  property p_etx;
    @(posedge clk) disable iff (sys_rst)
      (st_r.status[edie_pkg::BIT_EARLY_TX] && st_r.enable[edie_pkg::BIT_EARLY_TX]
       && st_r.enable[edie_pkg::BIT_ABN_SUM]) |-> gated[edie_pkg::BIT_EARLY_TX];
  endproperty
  a_etx: assert property (p_etx) else $error("early tx irq not passed");
  property p_resv;
    @(posedge clk) disable iff (sys_rst) st_r.enable[12:11] == 2'b00
      && st_r.enable[31:17] == 15'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved enable bit set");
  property p_erx;
    @(posedge clk) disable iff (sys_rst)
      gated[edie_pkg::BIT_EARLY_RX] |-> st_r.enable[edie_pkg::BIT_NRM_SUM];
  endproperty
  a_erx: assert property (p_erx) else $error("early rx irq without normal summary");
  property p_abn;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_ABN_SUM] |-> (gated & edie_pkg::ABN_GROUP) == 15'h0000;
  endproperty
  a_abn: assert property (p_abn) else $error("abnormal event passed while off");
  property p_nrm;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_NRM_SUM] |-> (gated & edie_pkg::NRM_GROUP) == 15'h0000;
  endproperty
  a_nrm: assert property (p_nrm) else $error("normal event passed while off");
  property p_txd;
    @(posedge clk) disable iff (sys_rst)
      (st_r.status[edie_pkg::BIT_TX_DONE] && st_r.enable[edie_pkg::BIT_TX_DONE]
       && st_r.enable[edie_pkg::BIT_NRM_SUM]) |=> dmaIrq;
  endproperty
  a_txd: assert property (p_txd) else $error("tx done irq missing");
  property p_sticky;
    @(posedge clk) disable iff (sys_rst) dmaEvent[3] |=> st_r.status[3] [*2] or
      (st_r.status[3] ##1 1'b1);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event not recorded");
  property p_irqor;
    @(posedge clk) disable iff (sys_rst) ##1 dmaIrq == $past(|gated);
  endproperty
  a_irqor: assert property (p_irqor) else $error("irq not or of gated events");
  property p_rst;
    @(posedge clk) $fell(sys_rst) |-> st_r.enable == 32'h00000000;
  endproperty
  a_rst: assert property (p_rst) else $error("enable not zero after reset");

  // ----------------------------------------------------------------
  // Assertions: individual enable off
  // ----------------------------------------------------------------
  property p_rxbu_off;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_RX_BUF_UNAV] |-> !gated[edie_pkg::BIT_RX_BUF_UNAV];
  endproperty
  a_rxbu_off: assert property (p_rxbu_off) else $error("rx buffer irq not masked");
  property p_wdog_off;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_RX_WDOG] |-> !gated[edie_pkg::BIT_RX_WDOG];
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("watchdog irq not masked");
  property p_etx_off;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_EARLY_TX] |-> !gated[edie_pkg::BIT_EARLY_TX];
  endproperty
  a_etx_off: assert property (p_etx_off) else $error("early tx irq not masked");
  property p_fbe_off;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_FATAL_BUS] |-> !gated[edie_pkg::BIT_FATAL_BUS];
  endproperty
  a_fbe_off: assert property (p_fbe_off) else $error("bus error irq not masked");
  property p_erx_off;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_EARLY_RX] |-> !gated[edie_pkg::BIT_EARLY_RX];
  endproperty
  a_erx_off: assert property (p_erx_off) else $error("early rx irq not masked");
  property p_txd_off;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_TX_DONE] |-> !gated[edie_pkg::BIT_TX_DONE];
  endproperty
  a_txd_off: assert property (p_txd_off) else $error("tx done irq not masked");

  // ----------------------------------------------------------------
  // Assertions: summary enable off
  // ----------------------------------------------------------------
  property p_rxbu_abn;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_ABN_SUM] |-> !gated[edie_pkg::BIT_RX_BUF_UNAV];
  endproperty
  a_rxbu_abn: assert property (p_rxbu_abn) else $error("rx buffer irq no summary");
  property p_rxstop_abn;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_ABN_SUM] |-> !gated[edie_pkg::BIT_RX_STOPPED];
  endproperty
  a_rxstop_abn: assert property (p_rxstop_abn) else $error("rx stop irq no summary");
  property p_etx_abn;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_ABN_SUM] |-> !gated[edie_pkg::BIT_EARLY_TX];
  endproperty
  a_etx_abn: assert property (p_etx_abn) else $error("early tx irq no summary");
  property p_fbe_abn;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_ABN_SUM] |-> !gated[edie_pkg::BIT_FATAL_BUS];
  endproperty
  a_fbe_abn: assert property (p_fbe_abn) else $error("bus error irq no summary");
  property p_txd_nrm;
    @(posedge clk) disable iff (sys_rst)
      !st_r.enable[edie_pkg::BIT_NRM_SUM] |-> !gated[edie_pkg::BIT_TX_DONE];
  endproperty
  a_txd_nrm: assert property (p_txd_nrm) else $error("tx done irq no summary");

  // ----------------------------------------------------------------
  // Assertions: enabled events reach the interrupt
  // ----------------------------------------------------------------
  sequence s_rxstop_on;
    st_r.status[edie_pkg::BIT_RX_STOPPED] && st_r.enable[edie_pkg::BIT_RX_STOPPED]
      && st_r.enable[edie_pkg::BIT_ABN_SUM];
  endsequence
  property p_rxstop_on;
    @(posedge clk) disable iff (sys_rst) s_rxstop_on |=> dmaIrq;
  endproperty
  a_rxstop_on: assert property (p_rxstop_on) else $error("rx stopped irq missing");
  sequence s_wdog_on;
    st_r.status[edie_pkg::BIT_RX_WDOG] && st_r.enable[edie_pkg::BIT_RX_WDOG]
      && st_r.enable[edie_pkg::BIT_ABN_SUM];
  endsequence
  property p_wdog_on;
    @(posedge clk) disable iff (sys_rst) s_wdog_on |=> dmaIrq;
  endproperty
  a_wdog_on: assert property (p_wdog_on) else $error("watchdog irq missing");
  sequence s_fbe_on;
    st_r.status[edie_pkg::BIT_FATAL_BUS] && st_r.enable[edie_pkg::BIT_FATAL_BUS]
      && st_r.enable[edie_pkg::BIT_ABN_SUM];
  endsequence
  property p_fbe_on;
    @(posedge clk) disable iff (sys_rst) s_fbe_on |=> dmaIrq;
  endproperty
  a_fbe_on: assert property (p_fbe_on) else $error("bus error irq missing");
  sequence s_erx_on;
    st_r.status[edie_pkg::BIT_EARLY_RX] && st_r.enable[edie_pkg::BIT_EARLY_RX]
      && st_r.enable[edie_pkg::BIT_NRM_SUM];
  endsequence
  property p_erx_on;
    @(posedge clk) disable iff (sys_rst) s_erx_on |=> dmaIrq;
  endproperty
  a_erx_on: assert property (p_erx_on) else $error("early rx irq missing");

  // ----------------------------------------------------------------
  // Assertions: status, enable writes and read back
  // ----------------------------------------------------------------
  property p_resv_evt;
    @(posedge clk) disable iff (sys_rst) gated[12:11] == 2'b00;
  endproperty
  a_resv_evt: assert property (p_resv_evt) else $error("reserved event gated");
  property p_irq_quiet;
    @(posedge clk) disable iff (sys_rst) gated == 15'h0000 |=> !dmaIrq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without gated event");
  property p_irq_on;
    @(posedge clk) disable iff (sys_rst) gated != 15'h0000 |=> dmaIrq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing for gated event");
  property p_evt_rec;
    @(posedge clk) disable iff (sys_rst)
      dmaEvent != 15'h0000 |=> (st_r.status & $past(dmaEvent)) == $past(dmaEvent);
  endproperty
  a_evt_rec: assert property (p_evt_rec) else $error("event not held in status");
  sequence s_clr_rxbu;
    wrStb && paddr == edie_pkg::OFF_STATUS && pwdata[edie_pkg::BIT_RX_BUF_UNAV] && pstrb[0];
  endsequence
  property p_w1c;
    @(posedge clk) disable iff (sys_rst)
      (s_clr_rxbu ##0 !dmaEvent[edie_pkg::BIT_RX_BUF_UNAV])
      |=> !st_r.status[edie_pkg::BIT_RX_BUF_UNAV];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");
  property p_setwins;
    @(posedge clk) disable iff (sys_rst)
      (s_clr_rxbu ##0 dmaEvent[edie_pkg::BIT_RX_BUF_UNAV])
      |=> st_r.status[edie_pkg::BIT_RX_BUF_UNAV];
  endproperty
  a_setwins: assert property (p_setwins) else $error("clear beat a new event");
  property p_enwr;
    @(posedge clk) disable iff (sys_rst)
      (wrStb && paddr == edie_pkg::OFF_ENABLE && pstrb == 4'hF)
      |=> st_r.enable == ($past(pwdata) & edie_pkg::ENABLE_WMASK);
  endproperty
  a_enwr: assert property (p_enwr) else $error("enable write wrong");
  property p_rsvd_rd;
    @(posedge clk) disable iff (sys_rst)
      (rdStb && paddr == edie_pkg::OFF_ENABLE)
      |-> prdata[31:17] == 15'h0000 && prdata[12:11] == 2'b00;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits read set");
  property p_evtread;
    @(posedge clk) disable iff (sys_rst)
      (rdStb && paddr == edie_pkg::OFF_EVENT) |-> prdata == {17'h00000, gated};
  endproperty
  a_evtread: assert property (p_evtread) else $error("gated events read wrong");
  property p_rst_irq;
    @(posedge clk) $fell(sys_rst) |-> !dmaIrq && st_r.status == 15'h0000;
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq or status after reset");
endmodule
`default_nettype wire

//--- bench/eth_dma_interrupt_enable_tb_top.sv
/*
  Self-checking bench for the DMA interrupt enable block.
  Assumes the package offsets, a zero-wait APB slave and a 20 MHz clock.
*/
`default_nettype none
module eth_dma_interrupt_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] dmaEvent;
  logic        dmaIrq;
  logic [31:0] rdData;
  logic        rdErr;
  int          n_mismatch;
  int          n_checks;

  edie_top u_edie_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dmaEvent(dmaEvent), .dmaIrq(dmaIrq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input int n);
    dmaEvent <= 15'h0001 << n;
    @(posedge clk);
    dmaEvent <= 15'h0000;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] irqW();
    return {31'h0, dmaIrq};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, edie_pkg::OFF_ENABLE, 32'h0);
    chk("enableReset", 32'h0, rdData);
    chk("slvErrMapped", 32'h0, {31'h0, rdErr});
    chk("readyIdle", 32'h1, {31'h0, pready});
    chk("irqReset", 32'h0, irqW());
    $display("test reset done");
  endtask

  task automatic t_gating();
    logic [31:0] sumEn;
    for (int n = 0; n < 15; n++) begin
      if (n == 11 || n == 12) continue;
      // Events 1,3,4,5,7,8,9,10,13 belong to the abnormal summary
      sumEn = (15'h27BA >> n) & 1 ? 32'h00008000 : 32'h00010000;
      apb(1'b1, edie_pkg::OFF_ENABLE, (32'h1 << n) | (sumEn ^ 32'h00018000));
      pulse(n);
      chk("irqWrongSummary", 32'h0, irqW());
      apb(1'b1, edie_pkg::OFF_ENABLE, (32'h1 << n) | sumEn);
      repeat (2) @(posedge clk);
      chk("irqEnabled", 32'h1, irqW());
      apb(1'b0, edie_pkg::OFF_EVENT, 32'h0);
      chk("gatedEvents", 32'h1 << n, rdData);
      apb(1'b1, edie_pkg::OFF_ENABLE, sumEn);
      repeat (2) @(posedge clk);
      chk("irqIndivOff", 32'h0, irqW());
      apb(1'b1, edie_pkg::OFF_STATUS, 32'h1 << n);
      apb(1'b0, edie_pkg::OFF_STATUS, 32'h0);
      chk("statusCleared", 32'h0, rdData);
    end
    $display("test gating done");
  endtask

  task automatic t_reserved();
    apb(1'b1, edie_pkg::OFF_ENABLE, 32'hFFFFFFFF);
    apb(1'b0, edie_pkg::OFF_ENABLE, 32'h0);
    chk("enableReserved", 32'h0001E7FF, rdData);
    pulse(11);
    pulse(12);
    chk("irqReservedEvt", 32'h0, irqW());
    apb(1'b1, edie_pkg::OFF_STATUS, 32'h00007FFF);
    apb(1'b1, edie_pkg::OFF_ENABLE, 32'h0);
    $display("test reserved done");
  endtask

  task automatic t_raw_status();
    pulse(7);
    apb(1'b0, edie_pkg::OFF_STATUS, 32'h0);
    chk("statusNoEnable", 32'h00000080, rdData);
    chk("irqNoEnable", 32'h0, irqW());
    apb(1'b1, edie_pkg::OFF_STATUS, 32'h00000080);
    $display("test raw status done");
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h0F0, 32'hFFFFFFFF);
    chk("slvErrWrite", 32'h1, {31'h0, rdErr});
    apb(1'b0, 12'h0F0, 32'h0);
    chk("slvErrRead", 32'h1, {31'h0, rdErr});
    chk("unmappedData", 32'h0, rdData);
    $display("test unmapped done");
  endtask

  task automatic t_strobe();
    pstrb <= 4'h1;
    apb(1'b1, edie_pkg::OFF_ENABLE, 32'hFFFFFFFF);
    pstrb <= 4'hF;
    apb(1'b0, edie_pkg::OFF_ENABLE, 32'h0);
    chk("enableLaneZero", 32'h000000FF, rdData);
    apb(1'b1, edie_pkg::OFF_ENABLE, 32'h0);
    $display("test strobe done");
  endtask

  task automatic t_set_wins();
    pulse(7);
    fork
      apb(1'b1, edie_pkg::OFF_STATUS, 32'h00000080);
      begin
        @(posedge clk);
        dmaEvent <= 15'h0080;
        @(posedge clk);
        dmaEvent <= 15'h0000;
      end
    join
    apb(1'b0, edie_pkg::OFF_STATUS, 32'h0);
    chk("statusSetWins", 32'h00000080, rdData);
    apb(1'b1, edie_pkg::OFF_STATUS, 32'h00000080);
    apb(1'b0, edie_pkg::OFF_STATUS, 32'h0);
    chk("statusClearOnly", 32'h0, rdData);
    $display("test set wins done");
  endtask

  task automatic t_rereset();
    apb(1'b1, edie_pkg::OFF_ENABLE, 32'h00018001);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, edie_pkg::OFF_ENABLE, 32'h0);
    chk("enableReReset", 32'h0, rdData);
    $display("test second reset done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    dmaEvent = 15'h0000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_gating();
    t_reserved();
    t_raw_status();
    t_unmapped();
    t_strobe();
    t_set_wins();
    t_rereset();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
